// >>> src/blink_pkg.sv
// shared constants and types for the status blink encoder
package blink_pkg;

	// ****************************************************************
	// timebase
	// ****************************************************************
	localparam int CLK_HZ         = 10_000_000;
	localparam int UNIT_MS        = 250;
	localparam int UNIT_CYCLES    = UNIT_MS * (CLK_HZ / 1000);
	localparam int ON_MS          = 250;
	localparam int GAP_MS         = 250;
	localparam int PAUSE_LONG_MS  = 2000;
	localparam int PAUSE_SHORT_MS = 1000;
	localparam logic [3:0] ON_UNITS          = 4'(ON_MS / UNIT_MS);
	localparam logic [3:0] GAP_UNITS         = 4'(GAP_MS / UNIT_MS);
	localparam logic [3:0] PAUSE_LONG_UNITS  = 4'(PAUSE_LONG_MS / UNIT_MS);
	localparam logic [3:0] PAUSE_SHORT_UNITS = 4'(PAUSE_SHORT_MS / UNIT_MS);
	localparam logic [3:0] LAST_UNIT         = 4'h1;

	// ****************************************************************
	// conditions and blink counts
	// ****************************************************************
	localparam logic [15:0] REV_SERIAL_ONE = 16'h0202;
	localparam logic [7:0]  FREQ_MIN_HZ    = 8'h2d;
	localparam logic [7:0]  FREQ_MAX_HZ    = 8'h42;
	localparam logic [2:0]  CNT_NORMAL     = 3'h1;
	localparam logic [2:0]  CNT_COMM       = 3'h2;
	localparam logic [2:0]  CNT_FREQ       = 3'h3;
	localparam logic [2:0]  CNT_BOTH       = 3'h4;
	localparam logic [2:0]  CNT_CHECKSUM   = 3'h5;
	localparam logic [2:0]  CNT_SERIAL     = 3'h6;
	localparam logic [2:0]  CNT_HWFAIL     = 3'h7;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [3:0]  ADDR_CTRL      = 4'h0;
	localparam logic [3:0]  ADDR_STATUS    = 4'h4;
	localparam logic [3:0]  ADDR_REV       = 4'h8;
	localparam int          CTRL_EN_BIT    = 0;
	localparam logic        CTRL_EN_RESET  = 1'h1;
	localparam int          STAT_SEL_LSB   = 0;
	localparam int          STAT_BURST_LSB = 4;
	localparam int          STAT_LAMP_BIT  = 8;
	localparam int          STAT_FREQ_BIT  = 9;
	localparam int          STAT_COMM_BIT  = 10;

	typedef enum logic [1:0] {PH_PAUSE, PH_ON, PH_GAP} phase_t;

endpackage : blink_pkg

// >>> src/timebase_if.sv
// unit tick link between the sequencer and its divider
interface timebase_if;
	logic run;
	logic tick;
	modport ctl (output run, input tick);
	modport gen (input run, output tick);
endinterface : timebase_if

// >>> src/unit_timer.sv
// divider giving one-cycle unit tick enables
module unit_timer
	import blink_pkg::*;
#(
	parameter int PERIOD = UNIT_CYCLES
) (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	timebase_if.gen   tb
);

	localparam logic [23:0] LAST = 24'(PERIOD - 1);

	typedef struct packed {
		logic [23:0] cnt;
		logic        tick;
	} timer_t;

	timer_t s;
	timer_t next_s;

	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (!tb.run) begin
			// restart so the first unit after enable is a full one
			next_s.cnt = '0;
		end else if (s.cnt == LAST) begin
			next_s.cnt = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt + 24'h000001;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tb.tick = s.tick;

endmodule : unit_timer

// >>> src/status_blink_encoder.sv
// status lamp blink pattern encoder with avalon-mm registers
// ****************************************************************
// How it works
// - with no fault the lamp gives one blink then a two second pause, and so does direct serial mode from revision 2.02.
// - a radio send failure gives two blinks then a one second pause.
// - a line frequency outside 45 to 66 Hz gives three blinks then a one second pause.
// - radio failure and frequency fault together give four blinks then a one second pause.
// - a firmware checksum fault gives five blinks then a one second pause.
// - direct serial mode before revision 2.02 gives six blinks then a one second pause.
// - an internal hardware failure gives seven blinks then a one second pause.
// ****************************************************************
module status_blink_encoder
	import blink_pkg::*;
#(
	parameter int UNIT_PERIOD = UNIT_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        radio_fail,
	input  wire logic [7:0]  line_freq_hz,
	input  wire logic        checksum_err,
	input  wire logic        hw_fail,
	input  wire logic        direct_serial,
	input  wire logic [15:0] fw_rev,
	output logic             lamp
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		phase_t      phase;
		logic [3:0]  units;
		logic [2:0]  left;
		logic [2:0]  burst;
		logic        lamp;
		logic        en;
		logic        ack;
		logic [31:0] rdata;
	} enc_t;

	enc_t s;
	enc_t next_s;
	logic [2:0] sel;
	logic       freq_bad;
	logic       bus_req;
	logic       tick;

	timebase_if tb ();

	unit_timer #(
		.PERIOD (UNIT_PERIOD)
	) u_timer (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.tb       (tb)
	);

	assign tb.run = s.en;
	assign tick   = tb.tick;

	// ****************************************************************
	// pattern selection
	// ****************************************************************
	assign freq_bad = (line_freq_hz < FREQ_MIN_HZ) ||
		(line_freq_hz > FREQ_MAX_HZ);

	// severity order: hardware, checksum, old serial mode, line faults
	always_comb begin
		if (hw_fail) begin
			sel = CNT_HWFAIL;
		end else if (checksum_err) begin
			sel = CNT_CHECKSUM;
		end else if (direct_serial && fw_rev < REV_SERIAL_ONE) begin
			sel = CNT_SERIAL;
		end else if (radio_fail && freq_bad) begin
			sel = CNT_BOTH;
		end else if (freq_bad) begin
			sel = CNT_FREQ;
		end else if (radio_fail) begin
			sel = CNT_COMM;
		end else begin
			sel = CNT_NORMAL;
		end
	end

	// ****************************************************************
	// bus and sequencer
	// ****************************************************************
	assign bus_req = avs_read || avs_write;

	always_comb begin
		next_s = s;
		next_s.ack = 1'b0;
		// bus: one wait cycle, read data prepared while waiting
		if (bus_req && !s.ack) begin
			next_s.ack = 1'b1;
			next_s.rdata = '0;
			case (avs_address)
				ADDR_CTRL: begin
					next_s.rdata[CTRL_EN_BIT] = s.en;
				end
				ADDR_STATUS: begin
					next_s.rdata[STAT_SEL_LSB +: 3] = sel;
					next_s.rdata[STAT_BURST_LSB +: 3] = s.burst;
					next_s.rdata[STAT_LAMP_BIT] = s.lamp;
					next_s.rdata[STAT_FREQ_BIT] = freq_bad;
					next_s.rdata[STAT_COMM_BIT] = radio_fail;
				end
				ADDR_REV: begin
					next_s.rdata[15:0] = fw_rev;
				end
				default: begin
					next_s.rdata = '0;
				end
			endcase
		end
		if (avs_write && s.ack && avs_address == ADDR_CTRL &&
				avs_byteenable[0]) begin
			next_s.en = avs_writedata[CTRL_EN_BIT];
		end
		// sequencer
		if (!s.en) begin
			// parked so the next pattern starts one unit after enable
			next_s.phase = PH_PAUSE;
			next_s.units = LAST_UNIT;
			next_s.left = '0;
			next_s.lamp = 1'b0;
		end else if (tick) begin
			if (s.units != LAST_UNIT) begin
				next_s.units = s.units - 4'h1;
			end else begin
				case (s.phase)
					PH_PAUSE: begin
						// pattern latched per burst so a burst never mixes
						next_s.burst = sel;
						next_s.left = sel;
						next_s.phase = PH_ON;
						next_s.units = ON_UNITS;
						next_s.lamp = 1'b1;
					end
					PH_ON: begin
						next_s.lamp = 1'b0;
						if (s.left == 3'h1) begin
							next_s.phase = PH_PAUSE;
							next_s.left = '0;
							if (s.burst == CNT_NORMAL) begin
								next_s.units = PAUSE_LONG_UNITS;
							end else begin
								next_s.units = PAUSE_SHORT_UNITS;
							end
						end else begin
							next_s.phase = PH_GAP;
							next_s.left = s.left - 3'h1;
							next_s.units = GAP_UNITS;
						end
					end
					PH_GAP: begin
						next_s.phase = PH_ON;
						next_s.units = ON_UNITS;
						next_s.lamp = 1'b1;
					end
					default: begin
						next_s.phase = PH_PAUSE;
						next_s.units = LAST_UNIT;
						next_s.lamp = 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '{phase: PH_PAUSE, units: LAST_UNIT, left: 3'h0,
				burst: 3'h0, lamp: 1'b0, en: CTRL_EN_RESET,
				ack: 1'b0, rdata: 32'h0};
		end else begin
			s <= next_s;
		end
	end

	assign avs_waitrequest = bus_req && !s.ack;
	assign avs_readdata    = s.rdata;
	assign lamp            = s.lamp;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	sequence pause_end;
		s.en && tick && s.phase == PH_PAUSE && s.units == LAST_UNIT;
	endsequence

	sequence last_blink_end;
		s.en && tick && s.phase == PH_ON && s.units == LAST_UNIT &&
			s.left == 3'h1;
	endsequence

	a_normal_sel: assert property (
		!hw_fail && !checksum_err && !radio_fail && !freq_bad &&
		!(direct_serial && fw_rev < REV_SERIAL_ONE) |-> sel == CNT_NORMAL)
		else $error("normal condition does not select one blink");

	a_comm_sel: assert property (
		!hw_fail && !checksum_err && !direct_serial && radio_fail &&
		!freq_bad |-> sel == CNT_COMM)
		else $error("radio failure does not select two blinks");

	a_freq_sel: assert property (
		!hw_fail && !checksum_err && !direct_serial && !radio_fail &&
		(line_freq_hz == 8'h2c || line_freq_hz == 8'h43) |->
		sel == CNT_FREQ)
		else $error("frequency fault does not select three blinks");

	a_both_sel: assert property (
		!hw_fail && !checksum_err && !direct_serial && radio_fail &&
		freq_bad |-> sel == CNT_BOTH)
		else $error("combined fault does not select four blinks");

	a_checksum_sel: assert property (
		!hw_fail && checksum_err |-> sel == CNT_CHECKSUM)
		else $error("checksum fault does not select five blinks");

	a_serial_sel: assert property (
		!hw_fail && !checksum_err && direct_serial &&
		fw_rev < REV_SERIAL_ONE |-> sel == CNT_SERIAL)
		else $error("old serial mode does not select six blinks");

	a_hwfail_sel: assert property (
		hw_fail |-> sel == CNT_HWFAIL)
		else $error("hardware failure does not select seven blinks");

	a_burst_start: assert property (
		pause_end |=> s.lamp && s.burst == $past(sel) &&
		s.left == $past(sel) && s.units == ON_UNITS)
		else $error("burst did not start with the selected count");

	a_pause_length: assert property (
		last_blink_end |=> !s.lamp && s.phase == PH_PAUSE &&
		s.units == ((s.burst == CNT_NORMAL) ?
		PAUSE_LONG_UNITS : PAUSE_SHORT_UNITS))
		else $error("pause after burst has the wrong length");

	a_blink_off: assert property (
		s.en && tick && s.phase == PH_ON && s.units == LAST_UNIT |=>
		!s.lamp ##0 (!s.lamp throughout (!tick [*1])))
		else $error("lamp did not go dark after its on time");

	a_lamp_disabled: assert property (
		!s.en |=> !lamp)
		else $error("lamp lit while disabled");

	a_bus_answer: assert property (
		bus_req && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered in one wait cycle");

	sequence blink_end;
		s.en && tick && s.phase == PH_ON && s.units == LAST_UNIT &&
			s.left != 3'h1;
	endsequence

	sequence gap_end;
		s.en && tick && s.phase == PH_GAP && s.units == LAST_UNIT;
	endsequence

	a_gap_start: assert property (
		blink_end |=> !s.lamp && s.phase == PH_GAP &&
		s.units == GAP_UNITS && s.left == $past(s.left) - 3'h1)
		else $error("gap after a blink has the wrong length");

	a_gap_end: assert property (
		gap_end |=> s.lamp && s.phase == PH_ON && s.units == ON_UNITS)
		else $error("blink after a gap did not light the lamp");

	a_burst_stable: assert property (
		s.phase != PH_PAUSE |=> s.burst == $past(s.burst))
		else $error("blink count changed inside a burst");

	a_lamp_phase: assert property (
		s.lamp |-> s.phase == PH_ON)
		else $error("lamp lit outside a blink");

	a_enable_write: assert property (
		avs_write && !avs_waitrequest && avs_address == ADDR_CTRL &&
		avs_byteenable[0] |=>
		s.en == $past(avs_writedata[CTRL_EN_BIT]))
		else $error("enable bit not taken from a control write");

	a_write_refused: assert property (
		avs_write && !avs_waitrequest &&
		(avs_address != ADDR_CTRL || !avs_byteenable[0]) |=>
		$stable(s.en))
		else $error("enable changed by a refused write");

	a_rev_read: assert property (
		avs_read && avs_waitrequest && avs_address == ADDR_REV |=>
		avs_readdata == {16'h0, $past(fw_rev)})
		else $error("revision read returned wrong data");

	a_unmapped_read: assert property (
		avs_read && avs_waitrequest && avs_address != ADDR_CTRL &&
		avs_address != ADDR_STATUS && avs_address != ADDR_REV |=>
		avs_readdata == 32'h0)
		else $error("unmapped read returned nonzero data");

endmodule : status_blink_encoder

// >>> sim/lamp_watch.sv
// lamp watcher standing in for the operator who reads the status lamp
module lamp_watch #(
	parameter int UNIT = 4
) (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	input  wire logic lamp,
	output logic      done,
	output logic [3:0] blinks,
	output int        pause
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	logic       prev;
	int         off;
	// a dark spell longer than one unit ends a burst; done reports it
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= 4'h0;
			prev <= 1'b0;
			off <= 0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (lamp && !prev) begin
				if (off > UNIT && cnt != 4'h0) begin
					blinks <= cnt;
					pause <= off;
					done <= 1'b1;
					cnt <= 4'h1;
				end else begin
					cnt <= cnt + 4'h1;
				end
			end
			off <= lamp ? 0 : off + 1;
			prev <= lamp;
		end
	end
endmodule : lamp_watch

// >>> sim/tb.sv
// self-checking bench for the status blink encoder
module tb
	import blink_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int U = 4;
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        radio_fail = 1'b0;
	logic [7:0]  line_freq_hz = 8'h32;
	logic        checksum_err = 1'b0;
	logic        hw_fail = 1'b0;
	logic        direct_serial = 1'b0;
	logic [15:0] fw_rev = 16'h0202;
	logic        lamp;
	logic        done;
	logic [3:0]  blinks;
	int          pause;
	int          error_cnt = 0;
	int          checks = 0;
	int          cycles = 0;
	logic [31:0] rd;
	logic [31:0] v;

	always #50 core_clk = ~core_clk;

	status_blink_encoder #(.UNIT_PERIOD(U)) u_dut (.core_clk(core_clk),
		.sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .radio_fail(radio_fail),
		.line_freq_hz(line_freq_hz), .checksum_err(checksum_err),
		.hw_fail(hw_fail), .direct_serial(direct_serial), .fw_rev(fw_rev),
		.lamp(lamp));
	lamp_watch #(.UNIT(U)) u_lamp (.core_clk(core_clk), .sys_rst(sys_rst),
		.lamp(lamp), .done(done), .blinks(blinks), .pause(pause));

	task automatic stop_test();
		$display("mismatches %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test

	// ends a hung wait on the bus or on the lamp
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			stop_test();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	function automatic logic freq_bad(input logic [7:0] q);
		return q < 8'h2d || q > 8'h42;
	endfunction : freq_bad

	function automatic logic [2:0] exp_cnt(input logic h, c, d,
		input logic [15:0] r, input logic f, input logic [7:0] q);
		if (h) return 3'h7;
		if (c) return 3'h5;
		if (d && r < 16'h0202) return 3'h6;
		if (f && freq_bad(q)) return 3'h4;
		if (freq_bad(q)) return 3'h3;
		if (f) return 3'h2;
		return 3'h1;
	endfunction : exp_cnt

	task automatic run_case(input logic h, c, d, input logic [15:0] r,
		input logic f, input logic [7:0] q);
		logic [2:0] e;
		e = exp_cnt(h, c, d, r, f, q);
		@(posedge core_clk);
		hw_fail <= h;
		checksum_err <= c;
		direct_serial <= d;
		fw_rev <= r;
		radio_fail <= f;
		line_freq_hz <= q;
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(32'(rd[2:0]), 32'(e));
		chk(32'(rd[10:9]), {30'h0, f, freq_bad(q)});
		bus(1'b0, ADDR_REV, 32'h0);
		chk(rd, {16'h0, r});
		// the first report may still belong to the old pattern
		@(posedge core_clk iff done === 1'b1);
		@(posedge core_clk iff done === 1'b1);
		chk(32'(blinks), 32'(e));
		chk(32'(pause), 32'((e == 3'h1 ? 8 : 4) * U));
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(32'(rd[STAT_BURST_LSB +: 3]), 32'(e));
	endtask : run_case

	task automatic meter_reset();
		@(posedge core_clk);
		sys_rst <= 1'b1;
		checksum_err <= 1'b0;
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
	endtask : meter_reset

	initial begin
		v = $urandom(32'he19a0604);
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		bus(1'b0, 4'hc, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, 32'h1);
		run_case(1'b0, 1'b0, 1'b0, 16'h0202, 1'b0, 8'h32);
		run_case(1'b0, 1'b0, 1'b0, 16'h0202, 1'b0, 8'h2d);
		run_case(1'b0, 1'b0, 1'b0, 16'h0202, 1'b0, 8'h42);
		run_case(1'b0, 1'b0, 1'b0, 16'h0202, 1'b0, 8'h2c);
		run_case(1'b0, 1'b0, 1'b0, 16'h0202, 1'b1, 8'h43);
		run_case(1'b0, 1'b0, 1'b0, 16'h0202, 1'b1, 8'h32);
		run_case(1'b0, 1'b1, 1'b1, 16'h0201, 1'b1, 8'h00);
		meter_reset();
		run_case(1'b0, 1'b0, 1'b1, 16'h0201, 1'b1, 8'h32);
		run_case(1'b0, 1'b0, 1'b1, 16'h0202, 1'b0, 8'h32);
		run_case(1'b1, 1'b1, 1'b1, 16'h0100, 1'b1, 8'hff);
		repeat (8) begin
			v = $urandom;
			run_case(v[0] & v[1], v[2] & v[3], v[4], {8'h02, v[15:8]},
				v[5], v[31:24]);
		end
		// lamp must stay dark while the enable is cleared
		bus(1'b1, ADDR_CTRL, 32'h0);
		// the lamp register follows the enable one cycle later
		@(posedge core_clk);
		repeat (40) begin
			@(negedge core_clk);
			chk(32'(lamp), 32'h0);
		end
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(32'(rd[STAT_LAMP_BIT]), 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h1);
		// a control write without its low byte lane must be ignored
		avs_byteenable <= 4'he;
		bus(1'b1, ADDR_CTRL, 32'h0);
		avs_byteenable <= 4'hf;
		bus(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, 32'h1);
		bus(1'b1, ADDR_REV, 32'hffff_ffff);
		run_case(1'b0, 1'b0, 1'b0, 16'h0202, 1'b0, 8'h32);
		stop_test();
	end
endmodule : tb
